/* File: slave_fifo_defines.vh */
// shared constants of the slave fifo port: widths, polarity bit positions, reset values, cycle counts
`ifndef SLAVE_FIFO_DEFINES_VH
`define SLAVE_FIFO_DEFINES_VH

// data and ring geometry
`define SFP_DATA_W 16
`define SFP_EP_AW 5
`define SFP_STREAM_DEPTH 32
`define SFP_STREAM_AW 5

// bit positions inside polarity_config, a set bit means active high
`define SFP_POL_READ 0
`define SFP_POL_WRITE 1
`define SFP_POL_OE 2
`define SFP_POL_CS 3
`define SFP_POL_COMMIT 4
`define SFP_POL_FLAG 5
`define SFP_POL_W 6

// reset values
`define SFP_DATA_RESET 16'h0000
`define SFP_PTR_RESET 6'h00

// pin sampling: two flops of synchroniser plus one event register
`define SFP_SYNC_STAGES 2
`define SFP_CLK_PERIOD_NS 40
`define SFP_ASYNC_PULSE_NS 50
`define SFP_ASYNC_PULSE_CYC ((`SFP_ASYNC_PULSE_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)

`endif

/* File: ring_memory.v */
// word memory behind the four endpoint rings: one write port, two registered read ports
module ring_memory #(
	parameter DW = 16,
	parameter AW = 7
) (
	input wire clock,
	input wire write_enable,
	input wire [AW-1:0] write_addr,
	input wire [DW-1:0] write_data,
	input wire [AW-1:0] read_addr_a,
	output reg [DW-1:0] read_data_a,
	input wire [AW-1:0] read_addr_b,
	output reg [DW-1:0] read_data_b
);

	reg [DW-1:0] store [0:(1 << AW) - 1];

	// no reset on the array so it maps onto block ram; read data lag the address by one edge
	always @(posedge clock) begin
		if (write_enable) begin
			store[write_addr] <= write_data;
		end
		read_data_a <= store[read_addr_a];
		read_data_b <= store[read_addr_b];
	end

endmodule

/* File: stream_fifo.v */
// valid/ready fifo with a registered output slot, used between the drain engine and the usb side
module stream_fifo #(
	parameter W = 19,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clock,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output reg out_valid,
	input wire out_ready,
	output reg [W-1:0] out_data
);

	reg [W-1:0] slot [0:DEPTH-1];
	reg [AW:0] count;
	reg [AW-1:0] wr_idx;
	reg [AW-1:0] rd_idx;
	wire push;
	wire pull;

	assign in_ready = (count != DEPTH[AW:0]);
	assign push = in_valid & in_ready;
	// refill the output slot when it is empty or being taken this cycle
	assign pull = (count != {(AW+1){1'b0}}) & (~out_valid | out_ready);

	always @(posedge clock) begin
		if (push) begin
			slot[wr_idx] <= in_data;
		end
	end

	// pointers, count and the output slot
	always @(posedge clock) begin
		if (!rst_n) begin
			count <= {(AW+1){1'b0}};
			wr_idx <= {AW{1'b0}};
			rd_idx <= {AW{1'b0}};
			out_valid <= 1'b0;
			out_data <= {W{1'b0}};
		end else begin
			if (push) begin
				wr_idx <= wr_idx + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pull) begin
				rd_idx <= rd_idx + {{(AW-1){1'b0}}, 1'b1};
				out_data <= slot[rd_idx];
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			if (push && !pull) begin
				count <= count + {{AW{1'b0}}, 1'b1};
			end else if (pull && !push) begin
				count <= count - {{AW{1'b0}}, 1'b1};
			end
		end
	end

endmodule

/* File: slave_fifo_port.v */
// slave fifo port: pin sampling, four endpoint rings, packet commit and drain to the usb side
`include "slave_fifo_defines.vh"

// Rules of the document; those naming the master bind the bus master, not this block
// [RULE_01] sync mode: each interface clock edge with read active advances the read pointer
// [RULE_02] output enable only drives the bus, never moves a pointer
// [RULE_03] sync mode: bus shows prefetched word at the read pointer before any read
// [RULE_04] a read counts only with chip select and read strobe both active
// [RULE_05] a write counts only with chip select and write strobe both active
// [RULE_06] sync mode: each interface clock edge with write active stores bus word
// [RULE_07] flags follow the new fill state right after each write edge
// [RULE_08] commit on the same edge as the last write includes that word
// [RULE_09] master keeps the fifo address stable while commit is active
// [RULE_10] auto mode: master spaces a one-word commit after the auto-committed packet
// [RULE_11] auto mode: packet commits itself once uncommitted words reach the length
// [RULE_12] master sets the fifo address up more than one interface clock early
// [RULE_13] async mode: output enable alone shows the word left from the last read
// [RULE_14] async mode: read assertion fetches the current word, then advances pointer
// [RULE_15] data drive only while output enable is active; read and enable may be tied
// [RULE_16] sync burst: each read edge moves pointer and presents the next word
// [RULE_17] master holds write and chip select through a sync burst write
// [RULE_18] fifo address selects flags and data every clock, with no interface edge; in async mode data_out changes only on a read
// [RULE_19] polarity of strobes, enable, select and flags is configurable
// [RULE_20] async mode: write strobe release stores the word, then the pointer moves
// [RULE_21] async mode: master never overlaps write strobe and commit
// [RULE_22] reads of an empty ring and writes of a full ring are ignored
module slave_fifo_port #(
	parameter DW = `SFP_DATA_W,
	parameter AW = `SFP_EP_AW,
	parameter STREAM_DEPTH = `SFP_STREAM_DEPTH,
	parameter STREAM_AW = `SFP_STREAM_AW
) (
	input wire clock,
	input wire rst_n,
	input wire interface_clock,
	input wire read_strobe,
	input wire write_strobe,
	input wire bus_output_enable,
	input wire port_chip_select,
	input wire packet_commit_strobe,
	input wire [1:0] fifo_select_address,
	input wire [DW-1:0] data_in,
	output reg [DW-1:0] data_out,
	output reg data_oe,
	output reg empty_flag,
	output reg full_flag,
	input wire sync_mode,
	input wire auto_mode,
	input wire [AW:0] auto_commit_length,
	input wire [`SFP_POL_W-1:0] polarity_config,
	input wire [3:0] endpoint_is_in,
	input wire fill_valid,
	input wire [1:0] fill_select,
	input wire [DW-1:0] fill_data,
	output reg fill_ready,
	output wire packet_valid,
	input wire packet_ready,
	output wire [DW-1:0] packet_data,
	output wire packet_last,
	output wire [1:0] packet_endpoint
);

	localparam DR_IDLE = 2'd0;
	localparam DR_FETCH = 2'd1;
	localparam DR_PUSH = 2'd2;
	localparam SYNC_W = 6 + 2 + DW;
	localparam SW = DW + 3;

	// maps a pin level to active-high, or an active-high flag to a pin level
	function pol_apply;
		input value;
		input active_high;
		begin
			pol_apply = ~(value ^ active_high);
		end
	endfunction

	function ring_empty;
		input [AW:0] w;
		input [AW:0] r;
		begin
			ring_empty = (w == r);
		end
	endfunction

	function ring_full;
		input [AW:0] w;
		input [AW:0] r;
		begin
			ring_full = (w[AW] != r[AW]) && (w[AW-1:0] == r[AW-1:0]);
		end
	endfunction

	// pin sampling, strobes already turned active high so a reset value of zero means idle
	reg [SYNC_W-1:0] sync1;
	reg [SYNC_W-1:0] sync2;
	wire [SYNC_W-1:0] pin_vector;
	wire s_clk;
	wire s_rd;
	wire s_wr;
	wire s_oe;
	wire s_cs;
	wire s_pe;
	wire [1:0] s_sel;
	wire [DW-1:0] s_data;
	reg clk_q;
	reg rd_q;
	reg wr_q;
	reg pe_q;

	// edge events, held one cycle in the event register before they act
	reg rd_now;
	reg wr_now;
	reg pe_now;
	reg ev_rd;
	reg ev_wr;
	reg ev_pe;
	reg [1:0] ev_sel;
	reg [DW-1:0] ev_data;

	// ring pointers: write, read and committed boundary per endpoint
	reg [AW:0] wr_ptr [0:3];
	reg [AW:0] rd_ptr [0:3];
	reg [AW:0] commit_ptr [0:3];
	reg [AW:0] next_wr [0:3];
	reg [AW:0] next_rd [0:3];
	reg [AW:0] next_commit [0:3];
	reg [AW:0] pending;
	integer i;
	integer j; // separate index so each loop variable has a single driving process

	reg wr_take;
	reg rd_take;
	wire fill_take;
	reg mem_we;
	reg [AW+1:0] mem_waddr;
	reg [DW-1:0] mem_wdata;
	wire [DW-1:0] rd_data_a;
	wire [DW-1:0] rd_data_b;

	// drain engine towards the usb side
	reg [1:0] dr_state;
	reg [1:0] dr_ep;
	wire st_in_ready;
	wire st_in_valid;
	wire [SW-1:0] st_in_data;
	wire [SW-1:0] st_out_data;
	wire drain_pop;
	wire [AW:0] rd_plus_one;

	assign pin_vector = {
		interface_clock,
		pol_apply(read_strobe, polarity_config[`SFP_POL_READ]), // RULE_19
		pol_apply(write_strobe, polarity_config[`SFP_POL_WRITE]),
		pol_apply(bus_output_enable, polarity_config[`SFP_POL_OE]),
		pol_apply(port_chip_select, polarity_config[`SFP_POL_CS]),
		pol_apply(packet_commit_strobe, polarity_config[`SFP_POL_COMMIT]),
		fifo_select_address,
		data_in
	};
	assign {s_clk, s_rd, s_wr, s_oe, s_cs, s_pe, s_sel, s_data} = sync2;

	// two-flop synchroniser; only sync2 is read by logic
	always @(posedge clock) begin
		if (!rst_n) begin
			sync1 <= {SYNC_W{1'b0}};
			sync2 <= {SYNC_W{1'b0}};
		end else begin
			sync1 <= pin_vector;
			sync2 <= sync1;
		end
	end

	// event detection: sync mode looks at interface clock rises, async mode at strobe edges
	always @* begin
		if (sync_mode) begin
			rd_now = s_clk & ~clk_q & s_rd & s_cs; // RULE_01 RULE_04 RULE_16
			wr_now = s_clk & ~clk_q & s_wr & s_cs; // RULE_06 RULE_05
			pe_now = s_clk & ~clk_q & s_pe & s_cs;
		end else begin
			rd_now = s_rd & ~rd_q & s_cs; // RULE_14 RULE_04
			wr_now = ~s_wr & wr_q & s_cs; // RULE_20 RULE_05
			pe_now = s_pe & ~pe_q & s_cs;
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			clk_q <= 1'b0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			pe_q <= 1'b0;
			ev_rd <= 1'b0;
			ev_wr <= 1'b0;
			ev_pe <= 1'b0;
			ev_sel <= 2'b00;
			ev_data <= `SFP_DATA_RESET;
		end else begin
			clk_q <= s_clk;
			rd_q <= s_rd;
			wr_q <= s_wr;
			pe_q <= s_pe;
			ev_rd <= rd_now;
			ev_wr <= wr_now;
			ev_pe <= pe_now;
			ev_sel <= s_sel;
			ev_data <= s_data;
		end
	end

	// takes: master writes go to in rings, master reads come from out rings
	always @* begin
		wr_take = ev_wr & endpoint_is_in[ev_sel] & ~ring_full(wr_ptr[ev_sel], rd_ptr[ev_sel]); // RULE_22
		rd_take = ev_rd & ~endpoint_is_in[ev_sel] & ~ring_empty(wr_ptr[ev_sel], rd_ptr[ev_sel]); // RULE_22
	end

	// fill_ready was low whenever a master event is in the event register, so no port clash
	assign fill_take = fill_valid & fill_ready & ~endpoint_is_in[fill_select]
		& ~ring_full(wr_ptr[fill_select], rd_ptr[fill_select]);

	// memory write port
	always @* begin
		mem_we = wr_take | fill_take;
		if (wr_take) begin
			mem_waddr = {ev_sel, wr_ptr[ev_sel][AW-1:0]}; // RULE_06 RULE_20
			mem_wdata = ev_data;
		end else begin
			mem_waddr = {fill_select, wr_ptr[fill_select][AW-1:0]};
			mem_wdata = fill_data;
		end
	end

	// next pointers; a write and a commit on one edge fold the word into the packet
	always @* begin
		pending = {(AW+1){1'b0}};
		for (i = 0; i < 4; i = i + 1) begin
			next_wr[i] = wr_ptr[i] + {{AW{1'b0}},
				((wr_take && ev_sel == i[1:0]) || (fill_take && fill_select == i[1:0]))};
			next_rd[i] = rd_ptr[i] + {{AW{1'b0}},
				((rd_take && ev_sel == i[1:0]) || (drain_pop && dr_ep == i[1:0]))}; // RULE_01 RULE_14
			next_commit[i] = commit_ptr[i];
			if (endpoint_is_in[i]) begin
				if (ev_pe && ev_sel == i[1:0]) begin
					next_commit[i] = next_wr[i]; // RULE_08
				end
				pending = next_wr[i] - commit_ptr[i];
				// a zero length disables auto commit
				if (auto_mode && auto_commit_length != {(AW+1){1'b0}} && pending >= auto_commit_length) begin
					next_commit[i] = next_wr[i]; // RULE_11
				end
			end
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			for (j = 0; j < 4; j = j + 1) begin
				wr_ptr[j] <= `SFP_PTR_RESET;
				rd_ptr[j] <= `SFP_PTR_RESET;
				commit_ptr[j] <= `SFP_PTR_RESET;
			end
		end else begin
			for (j = 0; j < 4; j = j + 1) begin
				wr_ptr[j] <= next_wr[j];
				rd_ptr[j] <= next_rd[j];
				commit_ptr[j] <= next_commit[j];
			end
		end
	end

	// port a always prefetches the word under the read pointer of the addressed ring
	ring_memory #(
		.DW(DW),
		.AW(AW + 2)
	) u_ring_memory (
		.clock(clock),
		.write_enable(mem_we),
		.write_addr(mem_waddr),
		.write_data(mem_wdata),
		.read_addr_a({s_sel, rd_ptr[s_sel][AW-1:0]}), // RULE_03 RULE_18
		.read_data_a(rd_data_a),
		.read_addr_b({dr_ep, rd_ptr[dr_ep][AW-1:0]}),
		.read_data_b(rd_data_b)
	);

	// bus side outputs; output enable touches nothing but data_oe
	always @(posedge clock) begin
		if (!rst_n) begin
			data_out <= `SFP_DATA_RESET;
			data_oe <= 1'b0;
			empty_flag <= pol_apply(1'b1, polarity_config[`SFP_POL_FLAG]);
			full_flag <= pol_apply(1'b0, polarity_config[`SFP_POL_FLAG]);
			fill_ready <= 1'b0;
		end else begin
			data_oe <= s_oe; // RULE_02 RULE_15
			if (sync_mode) begin
				data_out <= rd_data_a; // RULE_03 RULE_16
			end else if (rd_take) begin
				data_out <= rd_data_a; // RULE_14
			end
			// async without a read the bus keeps the last fetched word
			empty_flag <= pol_apply(ring_empty(next_wr[s_sel], next_rd[s_sel]),
				polarity_config[`SFP_POL_FLAG]); // RULE_07 RULE_18 RULE_19
			full_flag <= pol_apply(ring_full(next_wr[s_sel], next_rd[s_sel]),
				polarity_config[`SFP_POL_FLAG]); // RULE_07 RULE_18
			// low for one cycle after each accept and whenever a master event is pending
			fill_ready <= ~(rd_now | wr_now | pe_now) & ~fill_take & ~endpoint_is_in[fill_select]
				& ~ring_full(next_wr[fill_select], next_rd[fill_select]);
		end
	end

	// drain committed words of in rings into the stream fifo, one ring at a time
	assign rd_plus_one = rd_ptr[dr_ep] + {{AW{1'b0}}, 1'b1};
	assign st_in_valid = (dr_state == DR_PUSH);
	assign st_in_data = {dr_ep, (rd_plus_one == commit_ptr[dr_ep]), rd_data_b};
	assign drain_pop = st_in_valid & st_in_ready;

	always @(posedge clock) begin
		if (!rst_n) begin
			dr_state <= DR_IDLE;
			dr_ep <= 2'b00;
		end else begin
			case (dr_state)
				DR_IDLE: begin
					if (endpoint_is_in[dr_ep] && commit_ptr[dr_ep] != rd_ptr[dr_ep]) begin
						dr_state <= DR_FETCH;
					end else begin
						dr_ep <= dr_ep + 2'b01;
					end
				end
				DR_FETCH: begin
					dr_state <= DR_PUSH;
				end
				DR_PUSH: begin
					// a full stream fifo holds the engine here
					if (st_in_ready) begin
						dr_state <= DR_IDLE;
					end
				end
				default: begin
					dr_state <= DR_IDLE;
				end
			endcase
		end
	end

	stream_fifo #(
		.W(SW),
		.DEPTH(STREAM_DEPTH),
		.AW(STREAM_AW)
	) u_stream_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(st_in_valid),
		.in_ready(st_in_ready),
		.in_data(st_in_data),
		.out_valid(packet_valid),
		.out_ready(packet_ready),
		.out_data(st_out_data)
	);

	assign packet_endpoint = st_out_data[SW-1:SW-2];
	assign packet_last = st_out_data[DW];
	assign packet_data = st_out_data[DW-1:0];

endmodule

/* File: slave_fifo_port_assertions.sv */
// checker of the slave fifo port: timing relations seen at its ports
`include "slave_fifo_defines.vh"
module slave_fifo_port_checker #(
	parameter DW = 16
) (
	input wire clock,
	input wire rst_n,
	input wire read_strobe,
	input wire port_chip_select,
	input wire bus_output_enable,
	input wire [1:0] fifo_select_address,
	input wire sync_mode,
	input wire [`SFP_POL_W-1:0] polarity_config,
	input wire [3:0] endpoint_is_in,
	input wire [DW-1:0] data_out,
	input wire data_oe,
	input wire empty_flag,
	input wire full_flag,
	input wire fill_valid,
	input wire fill_ready,
	input wire packet_valid,
	input wire packet_ready,
	input wire [DW-1:0] packet_data,
	input wire packet_last,
	input wire [1:0] packet_endpoint
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock); endclocking
	wire oe_on = bus_output_enable == polarity_config[`SFP_POL_OE];
	wire cs_on = port_chip_select == polarity_config[`SFP_POL_CS];
	wire rd_on = cs_on && (read_strobe == polarity_config[`SFP_POL_READ]);
	wire flag_on = polarity_config[`SFP_POL_FLAG];
	reg [4:0] quiet;
	reg [1:0] last_addr;
	reg last_mode;
	// cycles since a read, an address change or a mode change; saturates so it never wraps
	always @(posedge clock) begin
		last_addr <= fifo_select_address;
		last_mode <= sync_mode;
		if (!rst_n || rd_on || last_addr != fifo_select_address || last_mode != sync_mode)
			quiet <= 5'h00;
		else if (quiet != 5'h1f)
			quiet <= quiet + 5'h01;
	end
	AST_RESET_OE: assert property (!rst_n |=> !data_oe)
		else $error("bus driven after reset");
	AST_RESET_FLAGS: assert property (!rst_n |=> empty_flag == flag_on && full_flag != flag_on)
		else $error("flags wrong after reset");
	AST_RESET_PKT: assert property (!rst_n |=> !packet_valid)
		else $error("packet valid after reset");
	AST_OE_OFF: assert property (disable iff (!rst_n) !oe_on [*5] |-> !data_oe)
		else $error("bus driven without enable");
	AST_FLAGS_EXCL: assert property (disable iff (!rst_n) !(empty_flag == flag_on && full_flag == flag_on))
		else $error("empty and full together");
	AST_ASYNC_HOLD: assert property (disable iff (!rst_n) !sync_mode && quiet > 5'h0c |=> $stable(data_out))
		else $error("async data moved without read");
	AST_PKT_HOLD: assert property (disable iff (!rst_n) packet_valid && !packet_ready |=>
		packet_valid && $stable({packet_data, packet_last, packet_endpoint}))
		else $error("stalled packet word changed");
	AST_PKT_IN_RING: assert property (disable iff (!rst_n) packet_valid |-> endpoint_is_in[packet_endpoint])
		else $error("packet from an out ring");
	AST_FILL_GAP: assert property (disable iff (!rst_n) fill_valid && fill_ready |=> !fill_ready)
		else $error("fill ready not dropped");
	COV_LAST: cover property (disable iff (!rst_n) packet_valid && packet_ready && packet_last);
	COV_ASYNC_DRIVE: cover property (disable iff (!rst_n) data_oe && !sync_mode);
	COV_SYNC_READ: cover property (disable iff (!rst_n) rd_on && sync_mode);
endmodule

bind slave_fifo_port slave_fifo_port_checker #(.DW(DW)) u_checker (
	.clock(clock), .rst_n(rst_n), .read_strobe(read_strobe), .port_chip_select(port_chip_select),
	.bus_output_enable(bus_output_enable), .fifo_select_address(fifo_select_address), .sync_mode(sync_mode),
	.polarity_config(polarity_config), .endpoint_is_in(endpoint_is_in), .data_out(data_out), .data_oe(data_oe),
	.empty_flag(empty_flag), .full_flag(full_flag), .fill_valid(fill_valid), .fill_ready(fill_ready),
	.packet_valid(packet_valid), .packet_ready(packet_ready), .packet_data(packet_data),
	.packet_last(packet_last), .packet_endpoint(packet_endpoint)
);

/* File: slave_fifo_master.sv */
// bus master model: drives the port's pins in sync or async style
module slave_fifo_master #(
	parameter [5:0] POL = 6'h2a
) (
	input wire clock,
	output logic interface_clock,
	output logic read_strobe,
	output logic write_strobe,
	output logic bus_output_enable,
	output logic port_chip_select,
	output logic packet_commit_strobe,
	output logic [1:0] fifo_select_address,
	output logic [15:0] data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// pins start inactive; an active pin equals its polarity bit
	initial begin
		interface_clock = 1'b0;
		{packet_commit_strobe, port_chip_select, bus_output_enable, write_strobe, read_strobe} = ~POL[4:0];
		fifo_select_address = 2'h0;
		data_in = 16'h0000;
	end
	task pins(input logic rd, input logic wr, input logic pe);
		@(posedge clock);
		read_strobe <= rd ~^ POL[0];
		write_strobe <= wr ~^ POL[1];
		packet_commit_strobe <= pe ~^ POL[4];
	endtask
	// address and select first, then two clocks of setup before any strobe
	task sel(input logic [1:0] a, input logic cs);
		@(posedge clock);
		fifo_select_address <= a;
		port_chip_select <= cs ~^ POL[3];
		repeat (2) @(posedge clock);
	endtask
	task oe(input logic on);
		@(posedge clock);
		bus_output_enable <= on ~^ POL[2];
	endtask
	// one interface clock period; strobes stay as set, so a burst keeps them held
	task cyc(input logic rd, input logic wr, input logic pe, input logic [15:0] d);
		pins(rd, wr, pe);
		data_in <= d;
		repeat (4) @(posedge clock);
		interface_clock <= 1'b1;
		repeat (4) @(posedge clock);
		interface_clock <= 1'b0;
	endtask
	// strobes released; the bus floats, so stale data shows as its inverse
	task idle;
		pins(1'b0, 1'b0, 1'b0);
		data_in <= ~data_in;
	endtask
	// async strobe: four clocks active, at least three idle, above the 50 ns minimum each way
	task apulse(input logic rd, input logic pe);
		pins(rd, 1'b0, pe);
		repeat (3) @(posedge clock);
		pins(1'b0, 1'b0, 1'b0);
		repeat (3) @(posedge clock);
	endtask
endmodule

/* File: slave_fifo_port_bench.sv */
// self-checking bench of the slave fifo port with a pin-level master model
module slave_fifo_port_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, rst_n, sync_mode, auto_mode, fill_valid, packet_ready;
	logic [5:0] auto_commit_length, polarity_config;
	logic [3:0] endpoint_is_in;
	logic [1:0] fill_select, fifo_select_address, packet_endpoint;
	logic [15:0] fill_data, data_in, data_out, packet_data;
	logic interface_clock, read_strobe, write_strobe, bus_output_enable, port_chip_select, packet_commit_strobe;
	logic data_oe, empty_flag, full_flag, fill_ready, packet_valid, packet_last;
	logic [18:0] got[$];
	int error_cnt = 0;
	int n_checks = 0;
	slave_fifo_master #(.POL(6'h2a)) u_master (.clock(clock), .interface_clock(interface_clock),
		.read_strobe(read_strobe), .write_strobe(write_strobe), .bus_output_enable(bus_output_enable),
		.port_chip_select(port_chip_select), .packet_commit_strobe(packet_commit_strobe),
		.fifo_select_address(fifo_select_address), .data_in(data_in));
	slave_fifo_port u_dut (.clock(clock), .rst_n(rst_n), .interface_clock(interface_clock),
		.read_strobe(read_strobe), .write_strobe(write_strobe), .bus_output_enable(bus_output_enable),
		.port_chip_select(port_chip_select), .packet_commit_strobe(packet_commit_strobe),
		.fifo_select_address(fifo_select_address), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.empty_flag(empty_flag), .full_flag(full_flag), .sync_mode(sync_mode), .auto_mode(auto_mode),
		.auto_commit_length(auto_commit_length), .polarity_config(polarity_config),
		.endpoint_is_in(endpoint_is_in), .fill_valid(fill_valid), .fill_select(fill_select),
		.fill_data(fill_data), .fill_ready(fill_ready), .packet_valid(packet_valid),
		.packet_ready(packet_ready), .packet_data(packet_data), .packet_last(packet_last),
		.packet_endpoint(packet_endpoint));
	// 25 MHz system clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// drained words logged as endpoint, last mark and data
	always @(posedge clock)
		if (packet_valid && packet_ready) got.push_back({packet_endpoint, packet_last, packet_data});
	task check(input string name, input logic [18:0] seen, input logic [18:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task test_done;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// usb-side fill of an out ring; ready is registered, so it is looked at between edges
	task fill(input logic [1:0] s, input logic [15:0] d);
		@(posedge clock);
		fill_valid <= 1'b1;
		fill_select <= s;
		fill_data <= d;
		@(negedge clock);
		for (int k = 0; k < 40 && fill_ready !== 1'b1; k++)
			@(negedge clock);
		check("fill ready", fill_ready, 1'b1);
		@(posedge clock);
		fill_valid <= 1'b0;
	endtask
	// one packet of n words counting up from d; the stream stays stalled until called
	task get_pkt(input int n, input logic [1:0] ep, input logic [15:0] d);
		@(posedge clock);
		packet_ready <= 1'b1;
		for (int k = 0; k < 300 && got.size() < n; k++)
			@(posedge clock);
		packet_ready <= 1'b0;
		for (int i = 0; i < n; i++)
			check("packet word", got.size() ? got.pop_front() : 19'h0_0000, {ep, i == n - 1, d + 16'(i)});
	endtask
	// sync writes: one without select is lost, then four words committed on the last edge
	task sc_write;
		u_master.sel(2'h0, 1'b0);
		u_master.cyc(1'b0, 1'b1, 1'b0, 16'hdead);
		u_master.idle;
		repeat (8) @(posedge clock);
		check("empty no select", empty_flag, 1'b1);
		u_master.sel(2'h0, 1'b1);
		for (int i = 0; i < 4; i++) begin
			u_master.cyc(1'b0, 1'b1, i == 3, 16'ha000 + 16'(i));
			repeat (2) @(posedge clock);
			if (i == 0) check("empty after write", empty_flag, 1'b0);
		end
		u_master.idle;
		get_pkt(4, 2'h0, 16'ha000);
	endtask
	// sync reads of out ring 1: prefetch, a read without select, a burst, a read on empty
	task sc_read;
		for (int i = 0; i < 3; i++)
			fill(2'h1, 16'hb000 + 16'(i));
		u_master.sel(2'h1, 1'b1);
		u_master.oe(1'b1);
		repeat (6) @(posedge clock);
		check("enable drives", data_oe, 1'b1);
		check("prefetch", data_out, 16'hb000);
		u_master.sel(2'h1, 1'b0);
		u_master.cyc(1'b1, 1'b0, 1'b0, 16'h0000);
		u_master.idle;
		u_master.sel(2'h1, 1'b1);
		check("read no select", data_out, 16'hb000);
		for (int i = 1; i < 4; i++) begin
			u_master.cyc(1'b1, 1'b0, 1'b0, 16'h0000);
			repeat (5) @(posedge clock);
			if (i < 3) check("burst word", data_out, 16'hb000 + 16'(i));
		end
		u_master.idle;
		repeat (4) @(posedge clock);
		check("empty after burst", empty_flag, 1'b1);
		u_master.cyc(1'b1, 1'b0, 1'b0, 16'h0000);
		u_master.idle;
		fill(2'h1, 16'hb100);
		repeat (8) @(posedge clock);
		check("read on empty", data_out, 16'hb100);
		u_master.oe(1'b0);
		repeat (6) @(posedge clock);
		check("enable off", data_oe, 1'b0);
	endtask
	// auto commit at three words, then a one-word packet committed a full period later
	task sc_auto;
		@(posedge clock);
		auto_commit_length <= 6'h03;
		auto_mode <= 1'b1;
		u_master.sel(2'h0, 1'b1);
		for (int i = 0; i < 4; i++)
			u_master.cyc(1'b0, 1'b1, 1'b0, 16'hc000 + 16'(i));
		u_master.cyc(1'b0, 1'b0, 1'b1, 16'h0000);
		u_master.idle;
		get_pkt(3, 2'h0, 16'hc000);
		get_pkt(1, 2'h0, 16'hc003);
		@(posedge clock);
		auto_mode <= 1'b0;
	endtask
	// async reads: enable alone keeps the last read word, a read strobe fetches the next
	task sc_async;
		fill(2'h1, 16'hd000);
		@(posedge clock);
		sync_mode <= 1'b0;
		u_master.sel(2'h1, 1'b1);
		u_master.oe(1'b1);
		u_master.apulse(1'b1, 1'b0);
		repeat (4) @(posedge clock);
		check("async read", data_out, 16'hb100);
		u_master.oe(1'b0);
		repeat (20) @(posedge clock);
		u_master.oe(1'b1);
		repeat (6) @(posedge clock);
		check("enable alone", data_out, 16'hb100);
		u_master.apulse(1'b1, 1'b0);
		repeat (4) @(posedge clock);
		check("async next", data_out, 16'hd000);
		check("async drive", data_oe, 1'b1);
		// ring 1 is drained now; flipping the flag polarity must invert both flag pins
		@(posedge clock);
		polarity_config <= 6'h0a;
		repeat (3) @(posedge clock);
		check("flag polarity", {empty_flag, full_flag}, 2'h1);
	endtask
	// reset for eight clocks, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		sync_mode = 1'b1;
		auto_mode = 1'b0;
		auto_commit_length = 6'h00;
		polarity_config = 6'h2a;
		endpoint_is_in = 4'h5;
		fill_valid = 1'b0;
		fill_select = 2'h0;
		fill_data = 16'h0000;
		packet_ready = 1'b0;
		repeat (7) @(posedge clock);
		@(negedge clock);
		check("reset flags", {empty_flag, full_flag, data_oe, packet_valid}, 4'h8);
		@(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		sc_write;
		sc_read;
		sc_auto;
		sc_async;
		test_done;
	end
	// hang guard, well beyond the few hundred cycles the scenarios need
	initial begin
		#400000;
		error_cnt++;
		test_done;
	end
endmodule
